// ### sbc_init_config_registers.sv
/*
 * sbc_init_config_registers: SPI-reached initialization configuration registers
 * (regulator and watchdog) with decoded settings for the supply logic.
 * Assumes SPI pins arrive asynchronously and are at least 4x slower than sys_clk_i;
 * init_mode_i comes from the mode controller on the same clock.
 */
// Notes on behaviour
// (R01) init registers take writes only while initialization mode is active
// (R02) regulator init register sits at address 0_0101, data in bits 7..0
// (R03) bit 7 picks cyclic-sense sync; reset value 1
// (R04) bits 6:5 pick undervoltage reset/interrupt thresholds 0.9 or 0.7
// (R05) bits 4:3 pick reset hold time 1, 5, 10 or 20 ms
// (R06) bit 2 picks auxiliary regulator 3.3 V or 5.0 V; reset value 0
// (R07) bits 1:0 pick cyclic-sense on time 200, 400, 800, 1600 us
// (R08) watchdog init register sits at address 0_0110, data in second byte
// (R09) watchdog init field layout; bits 6 and 1 reset to 1
// (R10) host sends parity bit 8 as zero when parity is unused
// (R11) host reads interrupt source within remaining period plus two periods
// (R12) writes outside initialization mode leave configuration unchanged
module sbc_init_config_registers (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // mode from device controller
    input wire logic init_mode_i,
    // spi pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    // configuration
    output sbc_pkg::sbc_regulator_cfg_t regulator_cfg_o,
    output sbc_pkg::sbc_watchdog_cfg_t watchdog_cfg_o,
    output sbc_pkg::sbc_derived_t derived_o,
    output logic write_ignored_o
);
    // synchronisers: stage 1 feeds stage 2 only; stage 3 is the edge history
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic [7:0] reg_regulator;
    logic [7:0] reg_watchdog;
    logic [7:0] rsp;
    logic miso;
    logic wr_ign;
    logic [7:0] next_reg_regulator;
    logic [7:0] next_reg_watchdog;
    logic [15:0] next_shift;
    logic [4:0] next_bit_cnt;
    logic [7:0] next_rsp;
    logic next_miso;
    logic next_wr_ign;
    sbc_pkg::sbc_derived_t next_derived;
    sbc_pkg::sbc_derived_t derived;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    logic frame_start;
    logic [4:0] cmd_addr;
    logic [1:0] cmd_mode;
    logic [2:0] next_sclk_s;
    logic [2:0] next_cs_s;
    logic [1:0] next_mosi_s;
    sbc_pkg::sbc_regulator_cfg_t next_reg_fields;

    always_comb
    begin
        next_sclk_s = {sclk_s[1:0], spi_sclk_i};
        next_cs_s = {cs_s[1:0], spi_cs_n_i};
        next_mosi_s = {mosi_s[0], spi_mosi_i};
    end

    // reset parks the history at the idle pin levels so no false edge follows reset
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            mosi_s <= 2'h0;
        end
        else
        begin
            sclk_s <= next_sclk_s;
            cs_s <= next_cs_s;
            mosi_s <= next_mosi_s;
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign frame_end = cs_s[1] & ~cs_s[2];
    assign frame_start = ~cs_s[1] & cs_s[2];
    assign cmd_mode = shift[sbc_pkg::CMD_MODE_MSB -: 2];
    assign cmd_addr = shift[sbc_pkg::CMD_ADDR_MSB:sbc_pkg::CMD_ADDR_LSB];

    always_comb
    begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_reg_regulator = reg_regulator;
        next_reg_watchdog = reg_watchdog;
        next_rsp = rsp;
        next_miso = miso;
        next_wr_ign = 1'b0;
        if (frame_start)
        begin
            next_bit_cnt = 5'h00;
            next_miso = rsp[7];
        end
        else if (!cs_s[1] && sclk_rise)
        begin
            next_shift = {shift[14:0], mosi_s[1]};
            // saturate so an overlong frame can never wrap back to a legal count
            if (bit_cnt != 5'h1F)
                next_bit_cnt = bit_cnt + 5'h01;
        end
        else if (!cs_s[1] && sclk_fall && bit_cnt < 5'h08)
        begin
            // answer byte of the previous read shifts out in the first byte
            next_miso = rsp[3'h7 - bit_cnt[2:0]];
        end
        // the parity position is not checked; the host keeps it at zero [R10]
        if (frame_end && bit_cnt == 5'(sbc_pkg::CMD_BITS))
        begin
            next_rsp = 8'h00;
            if (cmd_mode == sbc_pkg::CMD_WRITE)
            begin
                if (init_mode_i) // [R01] [R12]
                begin
                    if (cmd_addr == sbc_pkg::ADDR_INIT_REGULATOR) // [R02]
                        next_reg_regulator = shift[7:0];
                    if (cmd_addr == sbc_pkg::ADDR_INIT_WATCHDOG) // [R08]
                        next_reg_watchdog = shift[7:0];
                end
                else if (cmd_addr == sbc_pkg::ADDR_INIT_REGULATOR
                         || cmd_addr == sbc_pkg::ADDR_INIT_WATCHDOG)
                begin
                    next_wr_ign = 1'b1; // [R12]
                end
            end
            else if (cmd_mode == sbc_pkg::CMD_READ)
            begin
                if (cmd_addr == sbc_pkg::ADDR_INIT_REGULATOR)
                    next_rsp = reg_regulator;
                if (cmd_addr == sbc_pkg::ADDR_INIT_WATCHDOG)
                    next_rsp = reg_watchdog;
            end
        end
    end

    // decoded settings; reset value of the regulator register gives 0.9 reset,
    // 1 ms hold and 200 us on time
    always_comb
    begin
        next_reg_fields = next_reg_regulator;
        next_derived.uv_irq_at_high =
            (next_reg_fields.supply_undervolt_threshold_sel == sbc_pkg::UV_INT_HIGH_RST_LOW);
        next_derived.uv_reset_at_high =
            (next_reg_fields.supply_undervolt_threshold_sel != sbc_pkg::UV_INT_HIGH_RST_LOW)
            && (next_reg_fields.supply_undervolt_threshold_sel != sbc_pkg::UV_RST_LOW); // [R04]
        unique case (next_reg_fields.reset_pulse_length_sel) // [R05]
            2'h0: next_derived.reset_hold_cycles = sbc_pkg::RST_PULSE_CYC_00;
            2'h1: next_derived.reset_hold_cycles = sbc_pkg::RST_PULSE_CYC_01;
            2'h2: next_derived.reset_hold_cycles = sbc_pkg::RST_PULSE_CYC_10;
            2'h3: next_derived.reset_hold_cycles = sbc_pkg::RST_PULSE_CYC_11;
        endcase
        unique case (next_reg_fields.cyclic_on_time_sel) // [R07]
            2'h0: next_derived.cyclic_on_cycles = sbc_pkg::CYC_ON_CYC_00;
            2'h1: next_derived.cyclic_on_cycles = sbc_pkg::CYC_ON_CYC_01;
            2'h2: next_derived.cyclic_on_cycles = sbc_pkg::CYC_ON_CYC_10;
            2'h3: next_derived.cyclic_on_cycles = sbc_pkg::CYC_ON_CYC_11;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            shift <= 16'h0000;
            bit_cnt <= 5'h00;
            rsp <= 8'h00;
            miso <= 1'b0;
            wr_ign <= 1'b0;
        end
        else
        begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            rsp <= next_rsp;
            miso <= next_miso;
            wr_ign <= next_wr_ign;
        end
    end

    // configuration state: only a complete frame end moves it, so it stays quiet mid-frame
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            reg_regulator <= sbc_pkg::RST_INIT_REGULATOR; // [R03] [R06]
            reg_watchdog <= sbc_pkg::RST_INIT_WATCHDOG; // [R09]
            derived.uv_irq_at_high <= 1'b0;
            derived.uv_reset_at_high <= 1'b1;
            derived.reset_hold_cycles <= sbc_pkg::RST_PULSE_CYC_00;
            derived.cyclic_on_cycles <= sbc_pkg::CYC_ON_CYC_00;
        end
        else
        begin
            reg_regulator <= next_reg_regulator;
            reg_watchdog <= next_reg_watchdog;
            derived <= next_derived;
        end
    end

    // register fields map straight onto the struct layouts [R03] [R06] [R09]
    assign regulator_cfg_o = reg_regulator;
    assign watchdog_cfg_o = reg_watchdog;
    assign derived_o = derived;
    assign spi_miso_o = miso;
    assign write_ignored_o = wr_ign;
endmodule // sbc_init_config_registers

// ### sbc_init_config_registers_chk.sv
/* sbc_init_chk: port-level assertions for the init configuration registers.
   Assumes one clock domain and the package sbc_pkg compiled first. */
module sbc_init_chk (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // watched inputs
    input wire logic init_mode_i,
    input wire logic spi_cs_n_i,
    // watched outputs
    input sbc_pkg::sbc_regulator_cfg_t regulator_cfg_o,
    input sbc_pkg::sbc_watchdog_cfg_t watchdog_cfg_o,
    input sbc_pkg::sbc_derived_t derived_o,
    input wire logic write_ignored_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [19:0] HOLD [4] = '{20'h061A8, 20'h1E848, 20'h3D090, 20'h7A120};
    localparam logic [19:0] ON [4] = '{20'h01388, 20'h02710, 20'h04E20, 20'h09C40};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // updates only land a few clocks after chip select rises, never deep inside a frame
    sequence s_in_frame;
        !spi_cs_n_i [*8];
    endsequence
    property p_frame_quiet;
        s_in_frame |-> !write_ignored_o && $stable(regulator_cfg_o) && $stable(watchdog_cfg_o);
    endproperty
    a_frame_quiet: assert property (p_frame_quiet) else $error("config moved in frame");
    property p_reg_mode;
        $changed(regulator_cfg_o) |-> $past(init_mode_i);
    endproperty
    a_reg_mode: assert property (p_reg_mode) else $error("regulator write outside init");
    property p_wdg_mode;
        $changed(watchdog_cfg_o) |-> $past(init_mode_i);
    endproperty
    a_wdg_mode: assert property (p_wdg_mode) else $error("watchdog written outside init");
    property p_ign_keeps;
        write_ignored_o |-> !$past(init_mode_i) && $stable(regulator_cfg_o)
            && $stable(watchdog_cfg_o);
    endproperty
    a_ign_keeps: assert property (p_ign_keeps) else $error("refused write moved config");
    property p_ign_pulse;
        write_ignored_o |=> !write_ignored_o;
    endproperty
    a_ign_pulse: assert property (p_ign_pulse) else $error("refusal pulse too long");
    property p_hold;
        derived_o.reset_hold_cycles == HOLD[regulator_cfg_o.reset_pulse_length_sel];
    endproperty
    a_hold: assert property (p_hold) else $error("reset hold count wrong");
    property p_on;
        derived_o.cyclic_on_cycles == ON[regulator_cfg_o.cyclic_on_time_sel];
    endproperty
    a_on: assert property (p_on) else $error("cyclic on count wrong");
    property p_uv;
        derived_o.uv_irq_at_high == (regulator_cfg_o.supply_undervolt_threshold_sel == 2'h1) &&
        derived_o.uv_reset_at_high ==
            (regulator_cfg_o.supply_undervolt_threshold_sel inside {2'h0, 2'h3});
    endproperty
    a_uv: assert property (p_uv) else $error("undervolt decode wrong");
    property p_defaults;
        $rose(arst_n_i) |-> regulator_cfg_o == 8'h80 && watchdog_cfg_o == 8'h42;
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset values bad");
endmodule // sbc_init_chk

bind sbc_init_config_registers sbc_init_chk u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .init_mode_i(init_mode_i), .spi_cs_n_i(spi_cs_n_i), .regulator_cfg_o(regulator_cfg_o),
    .watchdog_cfg_o(watchdog_cfg_o), .derived_o(derived_o), .write_ignored_o(write_ignored_o));

// ### sbc_pkg.sv
/*
 * sbc_pkg: constants and field layouts for the initialization configuration registers.
 * Assumes a 25 MHz system clock and 16-bit SPI commands, MSB first.
 */
package sbc_pkg;
    // command layout
    localparam int CMD_BITS = 16;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam int CMD_MODE_MSB = 15;
    localparam int CMD_ADDR_MSB = 13;
    localparam int CMD_ADDR_LSB = 9;
    localparam int CMD_PARITY_BIT = 8;

    // register offsets
    localparam logic [4:0] ADDR_INIT_REGULATOR = 5'h05;
    localparam logic [4:0] ADDR_INIT_WATCHDOG = 5'h06;

    // reset values
    localparam logic [7:0] RST_INIT_REGULATOR = 8'h80;
    localparam logic [7:0] RST_INIT_WATCHDOG = 8'h42;

    // timing, rate and printed figures
    localparam int CLK_KHZ = 25000;
    localparam int RST_PULSE_US_00 = 1000;
    localparam int RST_PULSE_US_01 = 5000;
    localparam int RST_PULSE_US_10 = 10000;
    localparam int RST_PULSE_US_11 = 20000;
    localparam int CYC_ON_US_00 = 200;
    localparam int CYC_ON_US_01 = 400;
    localparam int CYC_ON_US_10 = 800;
    localparam int CYC_ON_US_11 = 1600;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] RST_PULSE_CYC_00 = CNT_W'(RST_PULSE_US_00 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] RST_PULSE_CYC_01 = CNT_W'(RST_PULSE_US_01 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] RST_PULSE_CYC_10 = CNT_W'(RST_PULSE_US_10 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] RST_PULSE_CYC_11 = CNT_W'(RST_PULSE_US_11 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] CYC_ON_CYC_00 = CNT_W'(CYC_ON_US_00 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] CYC_ON_CYC_01 = CNT_W'(CYC_ON_US_01 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] CYC_ON_CYC_10 = CNT_W'(CYC_ON_US_10 * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] CYC_ON_CYC_11 = CNT_W'(CYC_ON_US_11 * CLK_KHZ / 1000);

    // undervoltage response codes
    localparam logic [1:0] UV_RST_HIGH_A = 2'h0;
    localparam logic [1:0] UV_INT_HIGH_RST_LOW = 2'h1;
    localparam logic [1:0] UV_RST_LOW = 2'h2;

    typedef struct packed {
        logic cyclic_sync_sel;
        logic [1:0] supply_undervolt_threshold_sel;
        logic [1:0] reset_pulse_length_sel;
        logic aux_regulator_level_sel;
        logic [1:0] cyclic_on_time_sel;
    } sbc_regulator_cfg_t;

    typedef struct packed {
        logic irq_read_timeout_en;
        logic host_overcurrent_ctrl;
        logic overcurrent_timer_sel;
        logic safe_pin_second_reset;
        logic [1:0] watchdog_operation_sel;
        logic watchdog_window_sel;
        logic crank_option_sel;
    } sbc_watchdog_cfg_t;

    typedef struct packed {
        logic uv_irq_at_high;
        logic uv_reset_at_high;
        logic [CNT_W-1:0] reset_hold_cycles;
        logic [CNT_W-1:0] cyclic_on_cycles;
    } sbc_derived_t;
endpackage

// ### sbc_spi_host.sv
/* sbc_spi_host: behavioural host microcontroller acting as SPI master.
   Assumes the bench calls xfer one frame at a time; sclk half periods are 5 system clocks. */
module sbc_spi_host (
    // clock
    input wire logic sys_clk_i,
    // spi pins
    input wire logic spi_miso_i,
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rd = 8'h00;
    initial
    begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // rd is only updated at frame end so a pending check never sees a half-shifted byte
    task automatic xfer(input logic [15:0] w, input int n);
        logic [7:0] cap;
        cap = 8'h00;
        tick(1);
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_mosi_o = (i == 7) ? 1'b0 : w[15 - i];
            tick(5);
            cap = (i < 8) ? {cap[6:0], spi_miso_i} : cap;
            spi_sclk_o = 1'b1;
            tick(5);
            spi_sclk_o = 1'b0;
        end
        tick(5);
        spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        rd = cap;
        tick(10);
    endtask
endmodule // sbc_spi_host

// ### test_sbc_init_config_registers.sv
/* test_sbc_init_config_registers: self-checking bench for the init configuration registers.
   Assumes sbc_pkg, the design, its checker and the spi host model are compiled first. */
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_sbc_init_config_registers;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] rg;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [7:0] ign;
    } sbc_note_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic init_mode = 1'b1;
    logic sclk, cs_n, mosi, miso, ign;
    sbc_pkg::sbc_regulator_cfg_t rg;
    sbc_pkg::sbc_watchdog_cfg_t wd;
    sbc_pkg::sbc_derived_t dv;
    sbc_note_t notes[$];
    sbc_note_t e;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] ign_seen = 8'h00, x_rg = 8'h80, x_wd = 8'h42, x_ign = 8'h00, x_pend = 8'h00;
    logic [31:0] seed = 32'h0000000D;
    logic [19:0] hold [4] = '{20'h061A8, 20'h1E848, 20'h3D090, 20'h7A120};
    logic [19:0] on [4] = '{20'h01388, 20'h02710, 20'h04E20, 20'h09C40};
    sbc_init_config_registers DUT (.sys_clk_i(clk), .arst_n_i(arst_n), .init_mode_i(init_mode),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .regulator_cfg_o(rg), .watchdog_cfg_o(wd), .derived_o(dv), .write_ignored_o(ign));
    sbc_spi_host host (.sys_clk_i(clk), .spi_miso_i(miso), .spi_sclk_o(sclk),
        .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));
    initial
    begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // note the expected state first, then send; short frames must change nothing
    task automatic frame(input logic [1:0] op, input logic [4:0] a, input logic [7:0] d,
        input int n);
        sbc_note_t t;
        t.rd = x_pend;
        if (n == 16)
        begin
            if (op == 2'h1 && !init_mode && a inside {5'h05, 5'h06}) x_ign++;
            if (op == 2'h1 && init_mode && a == 5'h05) x_rg = d;
            if (op == 2'h1 && init_mode && a == 5'h06) x_wd = d;
            x_pend = (op != 2'h0) ? 8'h00 : (a == 5'h05) ? x_rg : (a == 5'h06) ? x_wd : 8'h00;
        end
        t.rg = x_rg;
        t.wd = x_wd;
        t.ign = x_ign;
        notes.push_back(t);
        host.xfer({op, a, 1'b0, d}, n);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (ign === 1'b1) ign_seen <= ign_seen + 8'h01;
        if (cyc == 6000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        wait (arst_n === 1'b1);
        forever
        begin
            @(posedge cs_n);
            repeat (8) @(posedge clk);
            #2;
            e = notes.pop_front();
            `CHK("regulator", e.rg, rg)
            `CHK("watchdog", e.wd, wd)
            `CHK("ignored", e.ign, ign_seen)
            `CHK("readback", e.rd, host.rd)
            `CHK("hold", hold[e.rg[4:3]], dv.reset_hold_cycles)
            `CHK("on", on[e.rg[1:0]], dv.cyclic_on_cycles)
            `CHK("uv", {e.rg[6:5] == 2'h1, e.rg[6:5] inside {2'h0, 2'h3}}, dv[41:40])
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        frame(2'h0, 5'h05, 8'h00, 16);
        frame(2'h0, 5'h06, 8'h00, 16);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            frame(2'h1, 5'h05, {seed[7], 2'(i), 2'(i), seed[2], 2'(i)}, 16);
            frame(2'h1, 5'h06, seed[15:8], 16);
        end
        frame(2'h1, 5'h05, 8'h5A, 15);
        frame(2'h0, 5'h05, 8'h00, 16);
        frame(2'h0, 5'h06, 8'h00, 16);
        init_mode = 1'b0;
        frame(2'h1, 5'h05, ~x_rg, 16);
        frame(2'h1, 5'h06, ~x_wd, 16);
        frame(2'h1, 5'h07, 8'hFF, 16);
        // reads follow within a few frames, well inside any interrupt-read deadline
        frame(2'h0, 5'h06, 8'h00, 16);
        frame(2'h0, 5'h05, 8'h00, 16);
        repeat (20) @(posedge clk);
        stop_test();
    end
endmodule // test_sbc_init_config_registers
